// ---- rtl/dbic_consts.svh ----
/*
  constants for the dma bus interface control block: register pointers,
  reset values, opcodes, command codes and fifo sizes. assumes inclusion by bare name.
*/
`ifndef DBIC_CONSTS_SVH
`define DBIC_CONSTS_SVH
`define DBIC_GRP_W 3
`define DBIC_RST_BYTE 8'h00
`define DBIC_RST_WORD 16'h0000
`define DBIC_RST_MASK 8'h7F
`define DBIC_INTERRUPT_RETURN_OPCODE_B0 8'hED
`define DBIC_INTERRUPT_RETURN_OPCODE_B1 8'h4D
`define DBIC_RD_LAST 3'h6
`define DBIC_FIFO_W 8
`define DBIC_FIFO_D 32
`define DBIC_CMD_LOAD 8'hCF
`define DBIC_CMD_ENABLE 8'h87
`define DBIC_CMD_DISABLE 8'h83
`define DBIC_CMD_RDSEQ 8'hA7
`define DBIC_CMD_RDSTAT 8'hBF
`endif

// ---- rtl/dbic_pkg.sv ----
/*
  types for the dma bus interface control block.
  assumes dbic_consts.svh is on the include path.
*/
package dbic_pkg;
  typedef enum logic [1:0] {
    DBIC_MODE_BYTE = 2'b00,
    DBIC_MODE_BURST = 2'b01,
    DBIC_MODE_CONT = 2'b10
  } dbic_mode_t;
  typedef enum logic [2:0] {
    DBIC_IDLE = 3'b000,
    DBIC_REQ = 3'b001,
    DBIC_RD = 3'b010,
    DBIC_WR = 3'b011,
    DBIC_REL = 3'b100
  } dbic_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic addr_oe;
    logic memory_request_n;
    logic io_request_n;
    logic rd_n;
    logic wr_n;
    logic strobe_oe;
  } dbic_bus_t;
endpackage

// ---- rtl/dbic_fifo.sv ----
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module dbic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- rtl/dbic_top.sv ----
/*
  single-channel dma bus interface control: bus request chain, interrupt
  chain, slave register access, port a/b address generation, pipelined
  count and match. assumes pins synchronous to sys_clk and external
  pin resolution from the output enables.
*/
`timescale 1ns/10ps
`include "dbic_consts.svh"
// Operation
// [RULE_01] low bus_grant_in means the system buses are released to us
// [RULE_02] bus_grant_out low only when no higher-priority dma requested
// [RULE_03] open-drain bus request; withhold while another dma requests
// [RULE_04] external decode drives select low for our port writes
// [RULE_05] in wait mode, low select stretches our bus cycles
// [RULE_06] priority_chain_out high only if chain in high and not in service
// [RULE_07] open-drain interrupt; io_request with fetch strobe is acknowledge
// [RULE_08] pulses on interrupt output only while we are bus master
// [RULE_09] slave access needs io_request, select and read or store strobe
// [RULE_10] as master drive io_request or memory_request per data cycle
// [RULE_11] decode two-byte interrupt return to leave service state
// [RULE_12] read strobe is status read input, driven output as master
// [RULE_13] store strobe is command write input, driven output as master
// [RULE_14] ready sampled with programmable polarity governs bus request
// [RULE_15] port a and b addresses multiplexed, source on read, dest on write
// [RULE_16] writable register groups and seven readable status registers
// [RULE_17] base byte pointer bits steer following bytes to associated regs
// [RULE_18] status reads in fixed sequence skipping masked registers
// [RULE_19] current address counters reloadable from starting buffers
// [RULE_20] byte counter increments per cycle, compared with block length
// [RULE_21] match flagged for a byte during read of the following byte
// [RULE_22] bus held until the operation finishes, no pre-emption
// [RULE_23] byte mode releases per byte; burst stops, continuous pauses
// [RULE_24] software programs length n-1, at least two bytes
// [RULE_25] address and strobes released while not bus master
// [RULE_26] register accesses ignored while we own the buses
module dbic_top
  import dbic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // bus chain
  input wire logic bus_grant_in_n,
  output logic bus_grant_out_n,
  input wire logic bus_request_line_in_n,
  output logic bus_request_line_out_n,
  output logic bus_request_line_oe,
  // interrupt chain
  input wire logic priority_chain_in,
  output logic priority_chain_out,
  output logic interrupt_out_n,
  output logic interrupt_oe,
  input wire logic instruction_fetch_strobe_n,
  // cpu strobes and select
  input wire logic select_or_stall_n,
  input wire logic io_request_in_n,
  input wire logic read_in_n,
  input wire logic store_in_n,
  input wire logic peripheral_ready,
  // data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // master bus outputs
  output dbic_bus_t bus_out,
  // configuration and status pins
  input wire logic wait_enable,
  input wire logic ready_active_high,
  input dbic_mode_t mode,
  input wire logic search_only,
  input wire logic a_is_source,
  input wire logic a_is_io,
  input wire logic b_is_io,
  input wire logic [1:0] a_step,
  input wire logic [1:0] b_step,
  input wire logic int_on_end,
  input wire logic int_on_match,
  input wire logic pulse_enable,
  output logic in_service,
  output logic enabled,
  output logic end_of_block,
  output logic match_found
);
  // registers
  logic [7:0] grp_q [7];
  logic [15:0] a_start_q, b_start_q, a_cur_q, b_cur_q, len_q, cnt_q;
  logic [7:0] mask_q, match_q, rdmask_q, pulse_q;
  logic [5:0] ptr_q;
  logic [2:0] ptr_grp_q, rd_idx_q, grp_id;
  logic en_q, req_q, master_q, srv_q, ip_q, interrupt_return_opcode_q, eob_q, mat_q;
  logic acc_q, pulse_q_n, prev_valid_q, eob_was_q, mat_was_q;
  logic [7:0] prev_q;
  dbic_state_t st_q;
  logic [7:0] rd_data;
  logic cpu_acc, cpu_wr, cpu_rd, ack, rdy, stall, last;
  logic f_valid, f_ready, o_valid, o_ready;
  logic [7:0] o_data;

  // slave decode
  // [RULE_09] port select decode
  assign cpu_acc = !master_q && !io_request_in_n && !select_or_stall_n
    && instruction_fetch_strobe_n && (!read_in_n || !store_in_n);
  // [RULE_26] no access while master
  assign cpu_wr = cpu_acc && !store_in_n && !acc_q;
  assign cpu_rd = cpu_acc && !read_in_n && !acc_q;
  // [RULE_07] acknowledge decode
  assign ack = !io_request_in_n && !instruction_fetch_strobe_n;
  // [RULE_14] ready polarity
  assign rdy = (peripheral_ready == ready_active_high);
  // [RULE_05] wait stretch
  assign stall = master_q && wait_enable && !select_or_stall_n;
  // [RULE_20] terminal count compare
  assign last = (cnt_q == len_q);
  // [RULE_17] commands ending in 3'h7 in group six; disable 8'h83 in group three
  assign grp_id = (data_in[2:0] == 3'h7) ? 3'h6 : data_in[2:0];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      acc_q <= 1'b0;
    end
    else
    begin
      acc_q <= cpu_acc;
    end
  end

  // register writes
  // [RULE_16] group storage
  // [RULE_17] pointer steering
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 7; i++)
      begin
        grp_q[i] <= `DBIC_RST_BYTE;
      end
      ptr_q <= '0;
      ptr_grp_q <= '0;
      a_start_q <= `DBIC_RST_WORD;
      b_start_q <= `DBIC_RST_WORD;
      len_q <= `DBIC_RST_WORD;
      mask_q <= `DBIC_RST_BYTE;
      match_q <= `DBIC_RST_BYTE;
      rdmask_q <= `DBIC_RST_MASK;
    end
    else if (cpu_wr)
    begin
      if (ptr_q != '0)
      begin
        ptr_q <= ptr_q & (ptr_q - 6'h01);
        unique case (ptr_grp_q)
          3'h0:
          begin
            if (ptr_q[0]) a_start_q[7:0] <= data_in;
            else if (ptr_q[1]) a_start_q[15:8] <= data_in;
            else if (ptr_q[2]) len_q[7:0] <= data_in;
            else len_q[15:8] <= data_in;
          end
          3'h3:
          begin
            if (ptr_q[0]) mask_q <= data_in;
            else match_q <= data_in;
          end
          3'h4:
          begin
            if (ptr_q[0]) b_start_q[7:0] <= data_in;
            else b_start_q[15:8] <= data_in;
          end
          3'h6: rdmask_q <= data_in;
          default: ;
        endcase
      end
      else
      begin
        ptr_grp_q <= grp_id;
        grp_q[grp_id] <= data_in;
        unique case (grp_id)
          3'h0: ptr_q <= {2'b00, data_in[6:3]};
          3'h3: ptr_q <= {4'h0, data_in[4:3]};
          3'h4: ptr_q <= {4'h0, data_in[4:3]};
          3'h6: ptr_q <= {5'h00, data_in == `DBIC_CMD_RDSEQ};
          default: ptr_q <= '0;
        endcase
      end
    end
  end

  // enable, read sequence
  // [RULE_18] masked read sequence
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_q <= 1'b0;
      rd_idx_q <= '0;
      pulse_q <= `DBIC_RST_BYTE;
    end
    else if (cpu_wr)
    begin
      en_q <= (ptr_q == '0) && (data_in == `DBIC_CMD_ENABLE);
      if (ptr_q == '0 && (data_in == `DBIC_CMD_RDSTAT || data_in == `DBIC_CMD_RDSEQ))
      begin
        rd_idx_q <= '0;
      end
    end
    else if (cpu_rd)
    begin
      rd_idx_q <= (rd_idx_q == `DBIC_RD_LAST) ? '0 : rd_idx_q + 3'h1;
    end
    else if (!rdmask_q[rd_idx_q])
    begin
      rd_idx_q <= (rd_idx_q == `DBIC_RD_LAST) ? '0 : rd_idx_q + 3'h1;
    end
    else if (st_q == DBIC_REL && eob_q)
    begin
      en_q <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (rd_idx_q)
      3'h0: rd_data = {2'b00, eob_q, mat_q, ip_q, 1'b0, rdy, master_q};
      3'h1: rd_data = cnt_q[7:0];
      3'h2: rd_data = cnt_q[15:8];
      3'h3: rd_data = a_cur_q[7:0];
      3'h4: rd_data = a_cur_q[15:8];
      3'h5: rd_data = b_cur_q[7:0];
      3'h6: rd_data = b_cur_q[15:8];
      default: rd_data = `DBIC_RST_BYTE;
    endcase
  end

  // bus master sequence
  // [RULE_22] hold until finished
  // [RULE_23] mode release policy
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q <= DBIC_IDLE;
      req_q <= 1'b0;
      master_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        DBIC_IDLE:
        begin
          // [RULE_03] withhold while another requests
          if (en_q && rdy && !eob_q && bus_request_line_in_n && !acc_q)
          begin
            req_q <= 1'b1;
            st_q <= DBIC_REQ;
          end
        end
        DBIC_REQ:
        begin
          // [RULE_01] grant taken
          if (!bus_grant_in_n)
          begin
            master_q <= 1'b1;
            st_q <= DBIC_RD;
          end
        end
        DBIC_RD:
        begin
          if (!stall && f_ready && rdy)
          begin
            st_q <= search_only ? DBIC_REL : DBIC_WR;
          end
          else if (!rdy && mode == DBIC_MODE_BURST)
          begin
            st_q <= DBIC_REL;
          end
        end
        DBIC_WR:
        begin
          if (!stall && o_valid)
          begin
            st_q <= DBIC_REL;
          end
        end
        DBIC_REL:
        begin
          if (eob_q || mode == DBIC_MODE_BYTE || (!rdy && mode == DBIC_MODE_BURST))
          begin
            req_q <= 1'b0;
            master_q <= 1'b0;
            st_q <= DBIC_IDLE;
          end
          else
          begin
            st_q <= DBIC_RD;
          end
        end
        default: st_q <= DBIC_IDLE;
      endcase
    end
  end

  // data path fifo
  assign f_valid = master_q && st_q == DBIC_RD && !stall && rdy && !search_only;
  assign o_ready = master_q && st_q == DBIC_WR && !stall;
  dbic_fifo #(.WIDTH(`DBIC_FIFO_W), .DEPTH(`DBIC_FIFO_D)) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(data_in),
    .out_valid(o_valid),
    .out_ready(o_ready),
    .out_data(o_data)
  );

  // counters and match
  // [RULE_19] reload from buffers
  // [RULE_20] count per byte
  // [RULE_21] delayed match
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      a_cur_q <= `DBIC_RST_WORD;
      b_cur_q <= `DBIC_RST_WORD;
      cnt_q <= `DBIC_RST_WORD;
      eob_q <= 1'b0;
      mat_q <= 1'b0;
      prev_q <= `DBIC_RST_BYTE;
      prev_valid_q <= 1'b0;
      pulse_q_n <= 1'b1;
    end
    else if (cpu_wr && ptr_q == '0 && data_in == `DBIC_CMD_LOAD)
    begin
      a_cur_q <= a_start_q;
      b_cur_q <= b_start_q;
      cnt_q <= `DBIC_RST_WORD;
      eob_q <= 1'b0;
      mat_q <= 1'b0;
      prev_valid_q <= 1'b0;
    end
    else if (st_q == DBIC_RD && !stall && f_ready && rdy)
    begin
      if (a_is_source)
        a_cur_q <= a_cur_q + {{14{a_step[1]}}, a_step[1] | a_step[0], 1'b0} - 16'h0001;
      else
        b_cur_q <= b_cur_q + {{14{b_step[1]}}, b_step[1] | b_step[0], 1'b0} - 16'h0001;
      prev_q <= data_in;
      prev_valid_q <= 1'b1;
      if (prev_valid_q && ((prev_q ^ match_q) & ~mask_q) == 8'h00)
      begin
        mat_q <= 1'b1;
      end
      cnt_q <= cnt_q + 16'h0001;
      eob_q <= last;
      // [RULE_08] pulse every 256 bytes
      pulse_q_n <= !(pulse_enable && cnt_q[7:0] == pulse_q);
    end
    else
    begin
      pulse_q_n <= 1'b1;
      if (st_q == DBIC_WR && o_ready && o_valid)
      begin
        if (a_is_source)
          b_cur_q <= b_cur_q + {{14{b_step[1]}}, b_step[1] | b_step[0], 1'b0} - 16'h0001;
        else
          a_cur_q <= a_cur_q + {{14{a_step[1]}}, a_step[1] | a_step[0], 1'b0} - 16'h0001;
      end
    end
  end

  // interrupt service
  // [RULE_11] return opcode decode
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ip_q <= 1'b0;
      srv_q <= 1'b0;
      interrupt_return_opcode_q <= 1'b0;
      eob_was_q <= 1'b0;
      mat_was_q <= 1'b0;
    end
    else
    begin
      eob_was_q <= eob_q;
      mat_was_q <= mat_q;
      if ((eob_q && !eob_was_q && int_on_end) || (mat_q && !mat_was_q && int_on_match))
        ip_q <= 1'b1;
      else if (ack && priority_chain_in)
        ip_q <= 1'b0;
      if (ack && ip_q && priority_chain_in)
        srv_q <= 1'b1;
      else if (interrupt_return_opcode_q && !instruction_fetch_strobe_n && data_in == `DBIC_INTERRUPT_RETURN_OPCODE_B1)
        srv_q <= 1'b0;
      if (!instruction_fetch_strobe_n && io_request_in_n)
        interrupt_return_opcode_q <= (data_in == `DBIC_INTERRUPT_RETURN_OPCODE_B0);
    end
  end

  // pin outputs
  // [RULE_02] grant chain
  assign bus_grant_out_n = bus_grant_in_n || req_q;
  assign bus_request_line_out_n = 1'b0;
  assign bus_request_line_oe = req_q;
  // [RULE_06] interrupt priority chain
  assign priority_chain_out = priority_chain_in && !srv_q;
  // [RULE_08] pulse only as master
  assign interrupt_out_n = 1'b0;
  assign interrupt_oe = master_q ? !pulse_q_n : (ip_q && priority_chain_in);
  assign data_out = master_q ? o_data : rd_data;
  assign data_oe = cpu_rd || (master_q && st_q == DBIC_WR);
  // [RULE_10] request strobes
  // [RULE_12] read strobe output
  // [RULE_13] store strobe output
  // [RULE_15] address multiplex
  // [RULE_25] release when not master
  always_comb
  begin
    bus_out.addr = (st_q == DBIC_WR) == a_is_source ? b_cur_q : a_cur_q;
    bus_out.addr_oe = master_q;
    bus_out.strobe_oe = master_q;
    bus_out.io_request_n = !(master_q && (((st_q == DBIC_WR) == a_is_source) ? b_is_io : a_is_io)
      && (st_q == DBIC_RD || st_q == DBIC_WR));
    bus_out.memory_request_n = !(master_q && bus_out.io_request_n && (st_q == DBIC_RD || st_q == DBIC_WR));
    bus_out.rd_n = !(master_q && st_q == DBIC_RD);
    bus_out.wr_n = !(master_q && st_q == DBIC_WR);
  end
  assign in_service = srv_q;
  assign enabled = en_q;
  assign end_of_block = eob_q;
  assign match_found = mat_q;
endmodule

// ---- tb/dbic_chk.sv ----
/*
  port checker for dbic_top.
  assumes a bind into dbic_top and dbic_consts.svh on the include path.
*/
`timescale 1ns/10ps
`include "dbic_consts.svh"
module dbic_chk
  import dbic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // chains
  input wire logic bus_grant_in_n,
  input wire logic bus_grant_out_n,
  input wire logic bus_request_line_in_n,
  input wire logic bus_request_line_out_n,
  input wire logic bus_request_line_oe,
  input wire logic priority_chain_in,
  input wire logic priority_chain_out,
  input wire logic interrupt_out_n,
  input wire logic interrupt_oe,
  input wire logic in_service,
  input wire logic enabled,
  // cpu side
  input wire logic instruction_fetch_strobe_n,
  input wire logic select_or_stall_n,
  input wire logic io_request_in_n,
  input wire logic read_in_n,
  input wire logic store_in_n,
  input wire logic [7:0] data_in,
  input wire logic data_oe,
  // master bus
  input dbic_bus_t bus_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // first cycle of a cpu store to us
  sequence s_cpu_write;
    !io_request_in_n && !select_or_stall_n && !store_in_n && $past(store_in_n)
      && instruction_fetch_strobe_n && !bus_request_line_oe;
  endsequence
  sequence s_cmd(logic [7:0] v);
    s_cpu_write ##0 (data_in == v);
  endsequence
  a_chain_out_gate:
    assert property (priority_chain_out == (priority_chain_in && !in_service))
    else $error("chain out wrong");
  a_grant_out_gate:
    assert property (bus_grant_out_n == (bus_grant_in_n || bus_request_line_oe))
    else $error("grant out wrong");
  a_req_drive_low:
    assert property (bus_request_line_oe |-> !bus_request_line_out_n)
    else $error("request not driven low");
  a_req_withhold:
    assert property ($rose(bus_request_line_oe) |-> $past(bus_request_line_in_n))
    else $error("request while line busy");
  a_bus_released:
    assert property (!bus_request_line_oe |-> !bus_out.addr_oe && !bus_out.strobe_oe)
    else $error("bus driven while not master");
  a_one_space:
    assert property (bus_out.strobe_oe && !(bus_out.rd_n && bus_out.wr_n)
      |-> bus_out.memory_request_n != bus_out.io_request_n)
    else $error("memory and io request clash");
  a_slave_read:
    assert property (data_oe && !bus_out.strobe_oe |-> !io_request_in_n
      && (!instruction_fetch_strobe_n || (!select_or_stall_n && !read_in_n)))
    else $error("data driven unaddressed");
  a_int_open_drain:
    assert property (interrupt_oe |-> !interrupt_out_n)
    else $error("interrupt not driven low");
  a_enable_cmd:
    assert property (s_cmd(`DBIC_CMD_ENABLE) |=> enabled)
    else $error("enable not taken");
  a_disable_cmd:
    assert property (s_cmd(`DBIC_CMD_DISABLE) |=> !enabled)
    else $error("disable not taken");
endmodule

bind dbic_top dbic_chk i_chk (
  .sys_clk, .srst, .bus_grant_in_n, .bus_grant_out_n, .bus_request_line_in_n,
  .bus_request_line_out_n, .bus_request_line_oe, .priority_chain_in,
  .priority_chain_out, .interrupt_out_n, .interrupt_oe, .in_service, .enabled,
  .instruction_fetch_strobe_n, .select_or_stall_n, .io_request_in_n, .read_in_n,
  .store_in_n, .data_in, .data_oe, .bus_out
);

// ---- tb/dbic_far_model.sv ----
/*
  far side model: cpu bus grant and a byte-wide memory.
  assumes the bench resolves the request line and the data bus.
*/
`timescale 1ns/10ps
module dbic_far_model
  import dbic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // arbitration
  input wire logic bus_line_n,
  input wire logic force_ack,
  output logic grant_n,
  // memory
  input dbic_bus_t bus_out,
  input wire logic [7:0] data_bus,
  output logic mem_oe,
  output logic [7:0] mem_q
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  initial
  begin
    last_q = 8'h00;
    for (int i = 0; i < 65536; i++)
    begin
      mem[i] = 8'(i) ^ 8'(i >> 8);
    end
  end
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      grant_n <= 1'b1;
    end
    else
    begin
      grant_n <= bus_line_n && !force_ack;
    end
  end
  // read drive, toggling when released
  assign mem_oe = bus_out.strobe_oe && !bus_out.memory_request_n && !bus_out.rd_n;
  assign mem_q = mem_oe ? mem[bus_out.addr] : ~last_q;
  always @(posedge sys_clk)
  begin
    last_q <= mem_q;
    if (bus_out.strobe_oe && !(bus_out.memory_request_n && bus_out.io_request_n) && !bus_out.wr_n)
    begin
      mem[bus_out.addr] <= data_bus;
    end
  end
endmodule

// ---- tb/tb_dma_bus_interface_control.sv ----
/*
  bench for dbic_top: command table, then two transfers with chains and interrupt.
  assumes dbic_far_model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`include "dbic_consts.svh"
module tb_dma_bus_interface_control
  import dbic_pkg::*;
;
  typedef struct packed {logic [7:0] cmd; logic chain; logic gnt_n; logic en;} dbic_row_t;
  typedef struct packed {dbic_mode_t md; logic [1:0] st; logic [7:0] b_hi; logic ioe;
    logic rah;} dbic_cfg_t;
  localparam dbic_row_t ROWS [0:7] = '{'{`DBIC_CMD_ENABLE, 1'b1, 1'b1, 1'b1},
    '{`DBIC_CMD_LOAD, 1'b0, 1'b0, 1'b0}, '{`DBIC_CMD_ENABLE, 1'b1, 1'b0, 1'b1},
    '{`DBIC_CMD_RDSEQ, 1'b0, 1'b1, 1'b0}, '{8'h7F, 1'b1, 1'b1, 1'b0},
    '{`DBIC_CMD_RDSTAT, 1'b1, 1'b0, 1'b0}, '{`DBIC_CMD_ENABLE, 1'b0, 1'b1, 1'b1},
    '{`DBIC_CMD_DISABLE, 1'b1, 1'b1, 1'b0}};
  localparam dbic_cfg_t CFGS [0:1] = '{'{DBIC_MODE_CONT, 2'b01, 8'h20, 1'b0, 1'b1},
    '{DBIC_MODE_BYTE, 2'b00, 8'h30, 1'b1, 1'b0}};
  logic sys_clk, srst, io_n, sel_n, rd_n, st_n, fetch_n, chain_in, rdy, rah, ioe;
  logic peer_n, force_ack, gnt_in_n, gnt_out_n, req_out_n, req_oe, req_line_n;
  logic chain_out, int_n, int_oe, data_oe, mem_oe, in_service, enabled, eob, mat;
  logic io_w, rd_w, st_w;
  logic [7:0] cpu_d, data_in, data_out, mem_q;
  logic [7:0] rb [0:6];
  logic [7:0] prog [0:11];
  logic [15:0] sa, da;
  dbic_mode_t md;
  logic [1:0] a_st;
  dbic_bus_t bus_out;
  dbic_cfg_t c;
  int checked, mismatches, n;
  // wire levels from every driver
  assign req_line_n = (req_oe ? req_out_n : 1'b1) && peer_n;
  assign data_in = data_oe ? data_out : (mem_oe ? mem_q : cpu_d);
  assign io_w = bus_out.strobe_oe ? bus_out.io_request_n : io_n;
  assign rd_w = bus_out.strobe_oe ? bus_out.rd_n : rd_n;
  assign st_w = bus_out.strobe_oe ? bus_out.wr_n : st_n;
  dbic_top i_dut (
    .sys_clk(sys_clk), .srst(srst), .bus_grant_in_n(gnt_in_n), .bus_grant_out_n(gnt_out_n),
    .bus_request_line_in_n(req_line_n), .bus_request_line_out_n(req_out_n),
    .bus_request_line_oe(req_oe), .priority_chain_in(chain_in),
    .priority_chain_out(chain_out), .interrupt_out_n(int_n), .interrupt_oe(int_oe),
    .instruction_fetch_strobe_n(fetch_n), .select_or_stall_n(sel_n),
    .io_request_in_n(io_w), .read_in_n(rd_w), .store_in_n(st_w), .peripheral_ready(rdy),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .bus_out(bus_out),
    .wait_enable(1'b0), .ready_active_high(rah), .mode(md), .search_only(1'b0),
    .a_is_source(1'b1), .a_is_io(1'b0), .b_is_io(ioe), .a_step(a_st), .b_step(a_st),
    .int_on_end(ioe), .int_on_match(ioe), .pulse_enable(ioe), .in_service(in_service),
    .enabled(enabled), .end_of_block(eob), .match_found(mat)
  );
  dbic_far_model i_far (
    .sys_clk(sys_clk), .srst(srst), .bus_line_n(req_line_n), .force_ack(force_ack),
    .grant_n(gnt_in_n), .bus_out(bus_out), .data_bus(data_in), .mem_oe(mem_oe),
    .mem_q(mem_q)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
  begin
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task automatic tally_and_finish();
  begin
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task automatic cpu_wr(input logic [7:0] v);
  begin
    @(posedge sys_clk);
    io_n <= 1'b0;
    sel_n <= 1'b0;
    st_n <= 1'b0;
    cpu_d <= v;
    @(posedge sys_clk);
    io_n <= 1'b1;
    sel_n <= 1'b1;
    st_n <= 1'b1;
    cpu_d <= ~v;
  end
  endtask
  task automatic cpu_rd(output logic [7:0] v);
  begin
    @(posedge sys_clk);
    io_n <= 1'b0;
    sel_n <= 1'b0;
    rd_n <= 1'b0;
    @(negedge sys_clk);
    v = data_oe ? data_out : 8'hXX;
    @(posedge sys_clk);
    io_n <= 1'b1;
    sel_n <= 1'b1;
    rd_n <= 1'b1;
  end
  endtask
  task automatic fetch(input logic [7:0] v, input logic io);
  begin
    @(posedge sys_clk);
    fetch_n <= 1'b0;
    io_n <= io;
    cpu_d <= v;
    @(posedge sys_clk);
    fetch_n <= 1'b1;
    io_n <= 1'b1;
    cpu_d <= ~v;
  end
  endtask
  initial
  begin
    {io_n, sel_n, rd_n, st_n, fetch_n, chain_in, peer_n, rah} = 8'hFF;
    {rdy, ioe, force_ack, srst} = 4'h1;
    cpu_d = 8'h00;
    md = DBIC_MODE_BYTE;
    a_st = 2'b01;
    checked = 0;
    mismatches = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk("grant out after reset", 1'b1, gnt_out_n);
    foreach (ROWS[i])
    begin
      @(posedge sys_clk);
      chain_in <= ROWS[i].chain;
      force_ack <= !ROWS[i].gnt_n;
      cpu_wr(ROWS[i].cmd);
      @(negedge sys_clk);
      chk("enabled", ROWS[i].en, enabled);
      chk("chain out", ROWS[i].chain, chain_out);
      chk("grant out", ROWS[i].gnt_n, gnt_out_n);
      chk("request idle", 1'b0, req_oe);
    end
    for (int p = 0; p < 2; p++)
    begin
      c = CFGS[p];
      @(posedge sys_clk);
      {force_ack, chain_in, a_st, ioe, rah, rdy} <= {2'b01, c.st, c.ioe, c.rah, c.rah};
      md <= c.md;
      prog = '{8'h78, 8'h00, 8'h10, 8'h01, 8'h00, 8'h1C, 8'h00, c.b_hi, 8'h1B, 8'h00, 8'h10,
        `DBIC_CMD_LOAD};
      foreach (prog[k])
        cpu_wr(prog[k]);
      peer_n <= 1'b0;
      cpu_wr(`DBIC_CMD_ENABLE);
      for (n = 0; n < 20; n++)
        @(negedge sys_clk) if (req_oe !== 1'b0) break;
      chk("withheld request", 20, n);
      @(posedge sys_clk);
      peer_n <= 1'b1;
      for (n = 0; n < 3000 && !(eob === 1'b1 && req_oe === 1'b0); n++)
        @(negedge sys_clk);
      if (n == 3000)
      begin
        mismatches++;
        tally_and_finish();
      end
      for (int i = 0; i < 3; i++)
      begin
        sa = c.st[0] ? 16'h1000 + i : 16'h1000 - i;
        da = c.st[0] ? {c.b_hi, 8'h00} + i : {c.b_hi, 8'h00} - i;
        if (i < 2)
          chk("dest byte", sa[7:0] ^ sa[15:8], i_far.mem[da]);
        else
          chk("past block end", da[7:0] ^ da[15:8], i_far.mem[da]);
      end
      cpu_wr(`DBIC_CMD_RDSEQ);
      cpu_wr(8'h7F);
      foreach (rb[k])
        cpu_rd(rb[k]);
      chk("status end bit", 1'b1, rb[0][5]);
      chk("status master bit", 1'b0, rb[0][0]);
      chk("port b high", c.st[0] ? c.b_hi : c.b_hi - 8'h01, rb[6]);
      chk("match found", 1'b1, mat);
      chk("interrupt request", c.ioe, int_oe);
      if (c.ioe)
      begin
        fetch(8'hFF, 1'b0);
        @(negedge sys_clk);
        chk("in service", 1'b1, in_service);
        chk("chain blocked", 1'b0, chain_out);
        fetch(`DBIC_INTERRUPT_RETURN_OPCODE_B0, 1'b1);
        fetch(`DBIC_INTERRUPT_RETURN_OPCODE_B1, 1'b1);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("service ended", 1'b0, in_service);
        chk("chain passed", 1'b1, chain_out);
        chk("interrupt cleared", 1'b0, int_oe);
      end
    end
    tally_and_finish();
  end
endmodule
